// *** rtl/amd_decoder.sv ***
// Operand addressing-mode decoder and effective-address sequencer.
// Assumes fetch and data memory answer with one-cycle acks on mclk.
`timescale 1ns/1ps
module amd_decoder
  import amd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic instr_valid,
  input wire amd_mode_t instr_mode,
  input wire amd_class_t instr_class,
  input wire amd_prefix_t instr_prefix,
  input wire logic [15:0] opcode_pc,
  input wire logic [7:0] index_x,
  input wire logic [7:0] index_y,
  output logic fetch_req,
  input wire logic fetch_ack,
  input wire logic [7:0] fetch_byte,
  output logic mem_rd_req,
  output logic [15:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [7:0] mem_rd_byte,
  output logic busy,
  output logic done,
  output logic refused,
  output amd_mode_t eff_mode,
  output logic use_second_index,
  output logic [15:0] ea,
  output logic [15:0] jump_target,
  output logic has_imm,
  output logic [7:0] imm_value,
  output logic [2:0] instr_len
);

  amd_ea_if eu ();
  amd_ea_unit u_ea (.eu(eu));

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  amd_state_t state_r, state_nxt;
  amd_mode_t mode_r, mode_nxt;
  amd_class_t class_r, class_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [1:0] need_r, need_nxt;
  logic [1:0] pneed_r, pneed_nxt;
  logic [7:0] idx_r, idx_nxt;
  logic [15:0] npc_r, npc_nxt;
  logic [2:0] len_r, len_nxt;
  logic [7:0] op0_r, op0_nxt, op1_r, op1_nxt;
  logic [15:0] ptr_r, ptr_nxt;
  logic ref_r, ref_nxt, y_r, y_nxt;
  logic freq_r, freq_nxt, mreq_r, mreq_nxt;
  logic [15:0] maddr_r, maddr_nxt;
  logic take_w;
  amd_mode_t em_w;
  logic ey_w;
  logic [2:0] elen_w;

  assign take_w = instr_valid && (state_r == AMD_S_IDLE) && !busy;

  // Prefix rewrites the base mode and index choice
  always_comb begin
    em_w = instr_mode;
    ey_w = 1'b0;
    unique case (instr_prefix)
      AMD_P_SECOND_INDEX_PREFIX: ey_w = 1'b1;
      AMD_P_INDIRECT_PREFIX, AMD_P_INDIRECT_SECOND_INDEX_PREFIX: begin
        ey_w = (instr_prefix == AMD_P_INDIRECT_SECOND_INDEX_PREFIX);
        unique case (instr_mode)
          AMD_M_DIR_S: em_w = AMD_M_IND_S;
          AMD_M_DIR_L: em_w = AMD_M_IND_L;
          AMD_M_BIT_D: em_w = AMD_M_BIT_I;
          AMD_M_BTR_D: em_w = AMD_M_BTR_I;
          AMD_M_REL_D: em_w = AMD_M_REL_I;
          AMD_M_IDX_S: em_w = AMD_M_IIX_S;
          AMD_M_IDX_L: em_w = AMD_M_IIX_L;
          default: em_w = instr_mode;
        endcase
      end
      default: ey_w = 1'b0;
    endcase
    elen_w = AMD_OPCODE_LEN + {1'b0, amd_operand_bytes(em_w)} +
             ((instr_prefix != AMD_P_NONE) ? AMD_PREFIX_LEN : 3'h0);
  end

  // Next-state logic: fetch operand bytes, then page-zero bytes
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    class_nxt = class_r;
    cnt_nxt = cnt_r;
    need_nxt = need_r;
    pneed_nxt = pneed_r;
    idx_nxt = idx_r;
    npc_nxt = npc_r;
    len_nxt = len_r;
    op0_nxt = op0_r;
    op1_nxt = op1_r;
    ptr_nxt = ptr_r;
    ref_nxt = ref_r;
    y_nxt = y_r;
    freq_nxt = freq_r;
    mreq_nxt = mreq_r;
    maddr_nxt = maddr_r;
    unique case (state_r)
      AMD_S_IDLE: begin
        if (take_w) begin
          mode_nxt = em_w;
          class_nxt = instr_class;
          y_nxt = ey_w;
          idx_nxt = ey_w ? index_y : index_x;
          len_nxt = elen_w;
          npc_nxt = opcode_pc + {13'h0000, elen_w} -
                    ((instr_prefix != AMD_P_NONE) ? 16'h0001 : 16'h0000);
          need_nxt = amd_operand_bytes(em_w);
          pneed_nxt = amd_ptr_bytes(em_w);
          cnt_nxt = AMD_RST_COUNT;
          op0_nxt = AMD_RST_BYTE;
          op1_nxt = AMD_RST_BYTE;
          ptr_nxt = AMD_RST_WORD;
          ref_nxt = ((em_w == AMD_M_IMM) && (instr_class != AMD_C_ALU)) ||
                    ((instr_class == AMD_C_RMW) && amd_is_long(em_w));
          if (ref_nxt || amd_operand_bytes(em_w) == 2'h0) begin
            state_nxt = AMD_S_FINISH;
          end else begin
            state_nxt = AMD_S_FETCH;
            freq_nxt = 1'b1;
          end
        end
      end
      AMD_S_FETCH: begin
        if (fetch_ack) begin
          if (cnt_r == 2'h0) begin
            op0_nxt = fetch_byte;
          end else begin
            op1_nxt = fetch_byte;
          end
          cnt_nxt = cnt_r + 2'h1;
          if (cnt_r + 2'h1 == need_r) begin
            freq_nxt = 1'b0;
            cnt_nxt = AMD_RST_COUNT;
            if (pneed_r != 2'h0) begin
              state_nxt = AMD_S_POINT;
              mreq_nxt = 1'b1;
              maddr_nxt = {AMD_PAGE_ZERO, (cnt_r == 2'h0) ? fetch_byte : op0_r};
            end else begin
              state_nxt = AMD_S_FINISH;
            end
          end
        end
      end
      AMD_S_POINT: begin
        if (mem_rd_ack) begin
          if (pneed_r == 2'h2 && cnt_r == 2'h0) begin
            ptr_nxt[15:8] = mem_rd_byte;
          end else begin
            ptr_nxt[7:0] = mem_rd_byte;
          end
          cnt_nxt = cnt_r + 2'h1;
          maddr_nxt = maddr_r + 16'h0001;
          if (cnt_r + 2'h1 == pneed_r) begin
            mreq_nxt = 1'b0;
            state_nxt = AMD_S_FINISH;
          end
        end
      end
      AMD_S_FINISH: state_nxt = AMD_S_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= AMD_S_IDLE;
      mode_r <= AMD_M_INH;
      class_r <= AMD_C_ALU;
      cnt_r <= AMD_RST_COUNT;
      need_r <= AMD_RST_COUNT;
      pneed_r <= AMD_RST_COUNT;
      idx_r <= AMD_RST_BYTE;
      npc_r <= AMD_RST_WORD;
      len_r <= AMD_OPCODE_LEN;
      op0_r <= AMD_RST_BYTE;
      op1_r <= AMD_RST_BYTE;
      ptr_r <= AMD_RST_WORD;
      ref_r <= 1'b0;
      y_r <= 1'b0;
      freq_r <= 1'b0;
      mreq_r <= 1'b0;
      maddr_r <= AMD_RST_WORD;
    end else if (ce) begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      class_r <= class_nxt;
      cnt_r <= cnt_nxt;
      need_r <= need_nxt;
      pneed_r <= pneed_nxt;
      idx_r <= idx_nxt;
      npc_r <= npc_nxt;
      len_r <= len_nxt;
      op0_r <= op0_nxt;
      op1_r <= op1_nxt;
      ptr_r <= ptr_nxt;
      ref_r <= ref_nxt;
      y_r <= y_nxt;
      freq_r <= freq_nxt;
      mreq_r <= mreq_nxt;
      maddr_r <= maddr_nxt;
    end
  end

  // Arithmetic operands
  assign eu.mode = mode_r;
  assign eu.index = idx_r;
  assign eu.op0 = op0_r;
  assign eu.op1 = op1_r;
  assign eu.ptr = ptr_r;
  assign eu.next_pc = npc_r;

  ////////////////////////////////////////////////////////////////////////////
  // Result registers, loaded on the finishing cycle
  logic busy_nxt, done_nxt;

  always_comb begin
    busy_nxt = (state_nxt != AMD_S_IDLE);
    done_nxt = (state_r == AMD_S_FINISH);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      refused <= 1'b0;
      eff_mode <= AMD_M_INH;
      use_second_index <= 1'b0;
      ea <= AMD_RST_WORD;
      jump_target <= AMD_RST_WORD;
      has_imm <= 1'b0;
      imm_value <= AMD_RST_BYTE;
      instr_len <= AMD_OPCODE_LEN;
    end else if (ce) begin
      busy <= busy_nxt;
      done <= done_nxt;
      if (done_nxt) begin
        refused <= ref_r;
        eff_mode <= mode_r;
        use_second_index <= y_r;
        ea <= ref_r ? AMD_RST_WORD : eu.ea;
        jump_target <= eu.target;
        has_imm <= (mode_r == AMD_M_IMM) && !ref_r;
        imm_value <= op0_r;
        instr_len <= len_r;
      end
    end
  end

  assign fetch_req = freq_r;
  assign mem_rd_req = mreq_r;
  assign mem_rd_addr = maddr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_mode_range: assert property (@(posedge mclk) disable iff (rst)
    done |-> eff_mode <= AMD_M_BTR_I) else $error("mode out of range");
  a_inherent_nofetch: assert property (@(posedge mclk) disable iff (rst)
    fetch_req |-> mode_r != AMD_M_INH && mode_r != AMD_M_IDX_0)
    else $error("fetch for no-operand mode");
  a_imm_value: assert property (@(posedge mclk) disable iff (rst)
    done && has_imm |-> imm_value == op0_r && instr_len >= 3'h2)
    else $error("immediate value wrong");
  a_dir_short: assert property (@(posedge mclk) disable iff (rst)
    done && eff_mode == AMD_M_DIR_S && !refused |-> ea == {8'h00, op0_r})
    else $error("short direct address wrong");
  a_dir_long: assert property (@(posedge mclk) disable iff (rst)
    done && eff_mode == AMD_M_DIR_L && !refused |-> ea == {op0_r, op1_r})
    else $error("long direct address wrong");
  a_idx_short: assert property (@(posedge mclk) disable iff (rst)
    done && eff_mode == AMD_M_IDX_S |-> ea == {8'h00, idx_r} + {8'h00, op0_r})
    else $error("short indexed sum wrong");
  a_idx_long: assert property (@(posedge mclk) disable iff (rst)
    done && eff_mode == AMD_M_IDX_L && !refused |-> ea == {op0_r, op1_r} + {8'h00, idx_r})
    else $error("long indexed sum wrong");
  a_ptr_page: assert property (@(posedge mclk) disable iff (rst)
    $rose(mem_rd_req) |-> mem_rd_addr == {8'h00, op0_r})
    else $error("pointer not in page zero");
  a_rel_target: assert property (@(posedge mclk) disable iff (rst)
    done && eff_mode == AMD_M_REL_D |->
    jump_target == npc_r + {{8{op0_r[7]}}, op0_r}) else $error("relative target wrong");
  a_rmw_long: assert property (@(posedge mclk) disable iff (rst)
    done && class_r == AMD_C_RMW && amd_is_long(eff_mode) |-> refused && !mem_rd_req)
    else $error("long form not refused");
  a_ind_prefix: assert property (@(posedge mclk) disable iff (rst)
    ce && take_w && instr_prefix == AMD_P_INDIRECT_PREFIX && instr_mode == AMD_M_IDX_S
    |=> mode_r == AMD_M_IIX_S && !y_r) else $error("indirect prefix ignored");
  a_done_pulse: assert property (@(posedge mclk) disable iff (rst)
    done && ce |=> !done) else $error("done longer than one cycle");

  c_indirect_long: cover property (@(posedge mclk) disable iff (rst)
    done && eff_mode == AMD_M_IIX_L);
  c_rel_indirect: cover property (@(posedge mclk) disable iff (rst)
    done && eff_mode == AMD_M_REL_I);
  c_refused: cover property (@(posedge mclk) disable iff (rst) done && refused);

endmodule

// *** rtl/amd_ea_if.sv ***
// Carrier between the decoder sequencer and its address arithmetic.
// Assumes both ends run on the core clock; the arithmetic is combinational.
`timescale 1ns/1ps
interface amd_ea_if;
  import amd_pkg::*;
  amd_mode_t mode;
  logic [7:0] index;
  logic [7:0] op0;
  logic [7:0] op1;
  logic [15:0] ptr;
  logic [15:0] next_pc;
  logic [15:0] ea;
  logic [15:0] target;

  modport calc (input mode, input index, input op0, input op1, input ptr,
                input next_pc, output ea, output target);
  modport ctl (output mode, output index, output op0, output op1, output ptr,
               output next_pc, input ea, input target);
endinterface

// *** rtl/amd_ea_unit.sv ***
// Effective address and relative target arithmetic.
// Assumes operands are stable registers of the sequencer.
`timescale 1ns/1ps
module amd_ea_unit
  import amd_pkg::*;
(
  amd_ea_if.calc eu
);

  logic [15:0] idx_w;
  logic [15:0] op_word_w;
  logic [7:0] disp_w;

  // Zero-extended operands so short sums carry into the high byte
  assign idx_w = {AMD_PAGE_ZERO, eu.index};
  assign op_word_w = {eu.op0, eu.op1};

  // Address by mode
  always_comb begin
    unique case (eu.mode)
      AMD_M_DIR_S, AMD_M_BIT_D, AMD_M_BTR_D: eu.ea = {AMD_PAGE_ZERO, eu.op0};
      AMD_M_DIR_L: eu.ea = op_word_w;
      AMD_M_IDX_0: eu.ea = idx_w;
      AMD_M_IDX_S: eu.ea = idx_w + {AMD_PAGE_ZERO, eu.op0};
      AMD_M_IDX_L: eu.ea = idx_w + op_word_w;
      AMD_M_IND_S, AMD_M_IND_L, AMD_M_BIT_I, AMD_M_BTR_I: eu.ea = eu.ptr;
      AMD_M_IIX_S, AMD_M_IIX_L: eu.ea = idx_w + eu.ptr;
      default: eu.ea = AMD_RST_WORD;
    endcase
  end

  // Signed displacement source, then target past the instruction
  always_comb begin
    unique case (eu.mode)
      AMD_M_REL_I: disp_w = eu.ptr[7:0];
      AMD_M_BTR_D, AMD_M_BTR_I: disp_w = eu.op1;
      default: disp_w = eu.op0;
    endcase
    eu.target = eu.next_pc + {{8{disp_w[7]}}, disp_w};
  end

endmodule

// *** rtl/amd_pkg.sv ***
// Shared types, constants and helpers of the addressing-mode decoder.
// Assumes one core clock; opcode decode outside supplies mode and class.
package amd_pkg;

  // Seventeen operand addressing modes, base form before any prefix
  typedef enum logic [4:0] {
    AMD_M_INH   = 5'h00,
    AMD_M_IMM   = 5'h01,
    AMD_M_DIR_S = 5'h02,
    AMD_M_DIR_L = 5'h03,
    AMD_M_IDX_0 = 5'h04,
    AMD_M_IDX_S = 5'h05,
    AMD_M_IDX_L = 5'h06,
    AMD_M_IND_S = 5'h07,
    AMD_M_IND_L = 5'h08,
    AMD_M_IIX_S = 5'h09,
    AMD_M_IIX_L = 5'h0a,
    AMD_M_REL_D = 5'h0b,
    AMD_M_REL_I = 5'h0c,
    AMD_M_BIT_D = 5'h0d,
    AMD_M_BIT_I = 5'h0e,
    AMD_M_BTR_D = 5'h0f,
    AMD_M_BTR_I = 5'h10
  } amd_mode_t;

  // Prefix byte seen ahead of the opcode
  typedef enum logic [1:0] {
    AMD_P_NONE                         = 2'h0,
    AMD_P_SECOND_INDEX_PREFIX          = 2'h1,
    AMD_P_INDIRECT_PREFIX              = 2'h2,
    AMD_P_INDIRECT_SECOND_INDEX_PREFIX = 2'h3
  } amd_prefix_t;

  // Instruction class as far as addressing legality goes
  typedef enum logic [1:0] {
    AMD_C_ALU  = 2'h0,
    AMD_C_RMW  = 2'h1,
    AMD_C_FLOW = 2'h2
  } amd_class_t;

  typedef enum logic [1:0] {
    AMD_S_IDLE   = 2'h0,
    AMD_S_FETCH  = 2'h1,
    AMD_S_POINT  = 2'h2,
    AMD_S_FINISH = 2'h3
  } amd_state_t;

  localparam logic [7:0] AMD_PAGE_ZERO = 8'h00;
  localparam logic [7:0] AMD_RST_BYTE = 8'h00;
  localparam logic [15:0] AMD_RST_WORD = 16'h0000;
  localparam logic [1:0] AMD_RST_COUNT = 2'h0;
  localparam logic [2:0] AMD_OPCODE_LEN = 3'h1;
  localparam logic [2:0] AMD_PREFIX_LEN = 3'h1;

  // Operand bytes that follow the opcode in program memory
  function automatic logic [1:0] amd_operand_bytes(amd_mode_t m);
    unique case (m)
      AMD_M_INH, AMD_M_IDX_0: amd_operand_bytes = 2'h0;
      AMD_M_DIR_L, AMD_M_IDX_L, AMD_M_BTR_D, AMD_M_BTR_I: amd_operand_bytes = 2'h2;
      default: amd_operand_bytes = 2'h1;
    endcase
  endfunction

  // Bytes read from page zero: pointer or relative displacement
  function automatic logic [1:0] amd_ptr_bytes(amd_mode_t m);
    unique case (m)
      AMD_M_IND_L, AMD_M_IIX_L: amd_ptr_bytes = 2'h2;
      AMD_M_IND_S, AMD_M_IIX_S, AMD_M_REL_I, AMD_M_BIT_I, AMD_M_BTR_I: amd_ptr_bytes = 2'h1;
      default: amd_ptr_bytes = 2'h0;
    endcase
  endfunction

  // Long forms reach the whole 64 Kbyte space
  function automatic logic amd_is_long(amd_mode_t m);
    amd_is_long = (m == AMD_M_DIR_L) || (m == AMD_M_IDX_L) ||
                  (m == AMD_M_IND_L) || (m == AMD_M_IIX_L);
  endfunction

endpackage

// *** test/addressing_mode_decoder_tb.sv ***
// Self-checking bench of the addressing-mode decoder, random and corner cases.
// Assumes the memory model answers fetches and page-zero reads behind the decoder.
`timescale 1ns/1ps
module addressing_mode_decoder_tb
  import amd_pkg::*;
;
  typedef struct packed {
    amd_mode_t m;
    amd_class_t c;
    amd_prefix_t p;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [15:0] pc;
  } amd_req_t;

  logic mclk, rst, ce, instr_valid, stall;
  amd_mode_t instr_mode;
  amd_class_t instr_class;
  amd_prefix_t instr_prefix;
  logic [15:0] opcode_pc, mem_rd_addr, ea, jump_target;
  logic [7:0] index_x, index_y, fetch_byte, mem_rd_byte, imm_value, prog_b0, prog_b1;
  logic fetch_req, fetch_ack, mem_rd_req, mem_rd_ack, busy, done, refused;
  logic use_second_index, has_imm;
  amd_mode_t eff_mode;
  logic [2:0] instr_len;
  int error_cnt = 0;
  int checks = 0;
  amd_req_t q[$];
  amd_req_t nx;

  amd_decoder dut (.mclk, .rst, .ce, .instr_valid, .instr_mode, .instr_class, .instr_prefix,
    .opcode_pc, .index_x, .index_y, .fetch_req, .fetch_ack, .fetch_byte, .mem_rd_req,
    .mem_rd_addr, .mem_rd_ack, .mem_rd_byte, .busy, .done, .refused, .eff_mode,
    .use_second_index, .ea, .jump_target, .has_imm, .imm_value, .instr_len);

  amd_mem_model mem (.mclk, .rst, .ce, .stall, .prog_b0, .prog_b1, .fetch_req, .fetch_ack,
    .fetch_byte, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_byte);

  ////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [7:0] mv(input logic [7:0] a);
    return a + 8'h3c;
  endfunction

  function automatic logic [1:0] opb(input amd_mode_t m);
    case (m)
      AMD_M_INH, AMD_M_IDX_0: return 2'h0;
      AMD_M_DIR_L, AMD_M_IDX_L, AMD_M_BTR_D, AMD_M_BTR_I: return 2'h2;
      default: return 2'h1;
    endcase
  endfunction

  // Mode after an indirect-type prefix
  function automatic amd_mode_t xm(input amd_mode_t m, input amd_prefix_t p);
    if (!p[1]) return m;
    case (m)
      AMD_M_DIR_S: return AMD_M_IND_S;
      AMD_M_DIR_L: return AMD_M_IND_L;
      AMD_M_BIT_D: return AMD_M_BIT_I;
      AMD_M_BTR_D: return AMD_M_BTR_I;
      AMD_M_REL_D: return AMD_M_REL_I;
      AMD_M_IDX_S: return AMD_M_IIX_S;
      AMD_M_IDX_L: return AMD_M_IIX_L;
      default: return m;
    endcase
  endfunction

  function automatic logic rf_of(input amd_req_t r, input amd_mode_t e);
    return (e == AMD_M_IMM && r.c != AMD_C_ALU) || (r.c == AMD_C_RMW &&
      e inside {AMD_M_DIR_L, AMD_M_IDX_L, AMD_M_IND_L, AMD_M_IIX_L});
  endfunction

  function automatic logic [15:0] ea_of(input amd_req_t r);
    logic [15:0] ix, ps, pl;
    ix = {8'h00, r.p[0] ? r.y : r.x};
    ps = {8'h00, mv(r.b0)};
    pl = {mv(r.b0), mv(r.b0 + 8'h01)};
    case (xm(r.m, r.p))
      AMD_M_DIR_S, AMD_M_BIT_D, AMD_M_BTR_D: return {8'h00, r.b0};
      AMD_M_DIR_L: return {r.b0, r.b1};
      AMD_M_IDX_0: return ix;
      AMD_M_IDX_S: return {8'h00, r.b0} + ix;
      AMD_M_IDX_L: return {r.b0, r.b1} + ix;
      AMD_M_IND_S, AMD_M_BIT_I, AMD_M_BTR_I: return ps;
      AMD_M_IND_L: return pl;
      AMD_M_IIX_S: return ps + ix;
      AMD_M_IIX_L: return pl + ix;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] jt_of(input amd_req_t r);
    amd_mode_t e;
    logic [7:0] d;
    e = xm(r.m, r.p);
    d = (e == AMD_M_REL_D) ? r.b0 : (e == AMD_M_REL_I) ? mv(r.b0) : r.b1;
    return r.pc + 16'h0001 + {14'h0000, opb(e)} + {{8{d[7]}}, d};
  endfunction

  // Request: every mode once, then corners, then random
  function automatic amd_req_t gen(input int i);
    amd_req_t r;
    r.m = amd_mode_t'(5'($urandom_range(0, 16)));
    r.c = amd_class_t'(2'($urandom_range(0, 2)));
    r.p = amd_prefix_t'(2'($urandom_range(0, 3)));
    r.x = 8'($urandom());
    r.y = 8'($urandom());
    r.b0 = 8'($urandom());
    r.b1 = 8'($urandom());
    r.pc = 16'($urandom());
    if (i < 17) r.m = amd_mode_t'(5'(i));
    case (i)
      17: r = '{AMD_M_IDX_S, AMD_C_ALU, AMD_P_NONE, 8'hff, 8'h00, 8'hff, 8'h00, 16'h0010};
      18: r = '{AMD_M_IDX_S, AMD_C_ALU, AMD_P_INDIRECT_PREFIX, 8'hff, 8'h00, 8'hc3, 8'h00,
                16'h0020};
      19: r = '{AMD_M_REL_D, AMD_C_FLOW, AMD_P_NONE, 8'h00, 8'h00, 8'h80, 8'h00, 16'h0100};
      20: r = '{AMD_M_REL_D, AMD_C_FLOW, AMD_P_NONE, 8'h00, 8'h00, 8'h7f, 8'h00, 16'hfff0};
      21: r = '{AMD_M_IMM, AMD_C_RMW, AMD_P_NONE, 8'h01, 8'h02, 8'h55, 8'h00, 16'h0200};
      22: r = '{AMD_M_DIR_L, AMD_C_RMW, AMD_P_NONE, 8'h01, 8'h02, 8'h12, 8'h34, 16'h0300};
      23: r = '{AMD_M_IDX_L, AMD_C_ALU, AMD_P_SECOND_INDEX_PREFIX, 8'h00, 8'hff, 8'hff, 8'hff,
                16'h0400};
      24: r = '{AMD_M_IMM, AMD_C_FLOW, AMD_P_NONE, 8'h01, 8'h02, 8'haa, 8'h00, 16'h0500};
      25: r = '{AMD_M_DIR_L, AMD_C_RMW, AMD_P_INDIRECT_PREFIX, 8'h01, 8'h02, 8'h10, 8'h00,
                16'h0600};
      26: r = '{AMD_M_REL_D, AMD_C_FLOW, AMD_P_INDIRECT_PREFIX, 8'h00, 8'h00, 8'h44, 8'h00,
                16'h0700};
      default: ;
    endcase
    if (r.p[1] && xm(r.m, r.p) == r.m) r.p = amd_prefix_t'({1'b0, r.p[0]});
    return r;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t result %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Result checker on each done pulse
  always @(negedge mclk) begin
    amd_req_t r;
    amd_mode_t e;
    logic rf;
    logic [15:0] xe;
    // Done stands while ce is low; look once, before the edge that drops it
    if (!rst && done === 1'b1 && ce === 1'b1) begin
      if (q.size() == 0) begin
        error_cnt++;
        $display("BAD %0t done with nothing pending", $time);
      end else begin
        r = q.pop_front();
        e = xm(r.m, r.p);
        rf = rf_of(r, e);
        chk(16'(refused), 16'(rf));
        xe = rf ? 16'h0000 : ea_of(r);
        chk(ea, xe);
        if (!rf) begin
          chk(16'(eff_mode), 16'(e));
          chk(16'(use_second_index), 16'(r.p[0]));
          chk(16'(instr_len), 16'(3'h1 + 3'(opb(e)) + 3'(r.p != AMD_P_NONE)));
          chk(16'(has_imm), 16'(e == AMD_M_IMM));
          if (e == AMD_M_IMM) chk(16'(imm_value), 16'(r.b0));
          if (e inside {AMD_M_REL_D, AMD_M_REL_I, AMD_M_BTR_D, AMD_M_BTR_I})
            chk(jump_target, jt_of(r));
        end
      end
    end
  end

  // Clock and far-side stall pattern
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) stall <= ($urandom_range(0, 3) == 0);

  // Clock enable dropped now and then, held high through reset
  always @(posedge mclk) ce <= rst || ($urandom_range(0, 7) != 0);

  // Watchdog, far beyond the expected run
  initial begin
    #500us;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: next request offered while busy, taken when idle
  initial begin
    int n;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_mode = AMD_M_INH;
    instr_class = AMD_C_ALU;
    instr_prefix = AMD_P_NONE;
    opcode_pc = 16'h0000;
    index_x = 8'h00;
    index_y = 8'h00;
    prog_b0 = 8'h00;
    prog_b1 = 8'h00;
    void'($urandom(93));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 400; i++) begin
      nx = gen(i);
      instr_valid <= 1'b1;
      instr_mode <= nx.m;
      instr_class <= nx.c;
      instr_prefix <= nx.p;
      opcode_pc <= nx.pc;
      index_x <= nx.x;
      index_y <= nx.y;
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (!(ce && instr_valid && !busy) && n < 500);
      if (n >= 500) begin
        error_cnt++;
        $display("BAD %0t request never taken", $time);
      end
      q.push_back(nx);
      prog_b0 <= nx.b0;
      prog_b1 <= nx.b1;
      if ($urandom_range(0, 2) == 0) begin
        instr_valid <= 1'b0;
        @(posedge mclk);
      end
    end
    instr_valid <= 1'b0;
    for (n = 0; n < 500 && q.size() != 0; n++) @(posedge mclk);
    if (q.size() != 0) begin
      error_cnt++;
      $display("BAD %0t results still pending", $time);
    end
    repeat (4) @(posedge mclk);
    summarize();
  end
endmodule

// *** test/amd_mem_model.sv ***
// Far-side model of the decoder: program fetch unit and page-zero data memory.
// Assumes the one-cycle acknowledge contract on mclk, a bench-driven stall and
// the decoder's clock enable, with which the model freezes.
`timescale 1ns/1ps
module amd_mem_model
  import amd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic stall,
  input wire logic [7:0] prog_b0,
  input wire logic [7:0] prog_b1,
  input wire logic fetch_req,
  output logic fetch_ack,
  output logic [7:0] fetch_byte,
  input wire logic mem_rd_req,
  input wire logic [15:0] mem_rd_addr,
  output logic mem_rd_ack,
  output logic [7:0] mem_rd_byte
);
  logic fetch_ack_nxt;
  logic mem_rd_ack_nxt;
  logic cnt_r;
  logic cnt_nxt;
  logic [7:0] sel_byte;
  logic [7:0] mem_val;

  ////////////////////////////////////////////////////////////////////////////
  // Next acks: one pulse per wanted byte, held off while stalling
  always_comb begin
    fetch_ack_nxt = fetch_req && !fetch_ack && !stall;
    mem_rd_ack_nxt = mem_rd_req && !mem_rd_ack && !stall;
    cnt_nxt = fetch_req ? (cnt_r | fetch_ack) : 1'b0;
  end

  // Registers of the model; an ack left standing while ce is low is taken later
  always_ff @(posedge mclk) begin
    if (rst) begin
      fetch_ack <= 1'b0;
      mem_rd_ack <= 1'b0;
      cnt_r <= 1'b0;
    end else if (ce) begin
      fetch_ack <= fetch_ack_nxt;
      mem_rd_ack <= mem_rd_ack_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // High byte first; inverse value off the ack so stale data never passes
  assign sel_byte = cnt_r ? prog_b1 : prog_b0;
  assign fetch_byte = fetch_ack ? sel_byte : ~sel_byte;
  assign mem_val = mem_rd_addr[7:0] + 8'h3c;
  assign mem_rd_byte = mem_rd_ack ? mem_val : ~mem_val;
endmodule
